// ### ssp_pkg.sv
// package: constants and carrier types for the synchronous serial port pin block
package ssp_pkg;
  // serial clock divider selections (divide by 2, 4, 8, 16)
  localparam logic [1:0] SSP_DIV2 = 2'h0;
  localparam logic [1:0] SSP_DIV4 = 2'h1;
  localparam logic [1:0] SSP_DIV8 = 2'h2;
  localparam logic [1:0] SSP_DIV16 = 2'h3;
  // internal clock cycles per serial clock half period minus one, per selection
  localparam logic [2:0] SSP_HALF2 = 3'h0;
  localparam logic [2:0] SSP_HALF4 = 3'h1;
  localparam logic [2:0] SSP_HALF8 = 3'h3;
  localparam logic [2:0] SSP_HALF16 = 3'h7;
  // serial clock cycles in one transfer
  localparam logic [3:0] SSP_BITS = 4'h8;
  localparam logic [2:0] SSP_LAST_BIT = 3'h7;
  // port numbers
  localparam logic SSP_PORT0 = 1'b0;
  localparam logic SSP_PORT1 = 1'b1;

  // transfer engine states
  typedef enum logic [1:0] {
    SSP_IDLE = 2'b00,
    SSP_LOW = 2'b01,
    SSP_HIGH = 2'b10
  } ssp_state_e;

  // request from the register side: one access starts one byte transfer
  typedef struct packed {
    logic start;
    logic port;
    logic write;
    logic [1:0] div_sel;
    logic [7:0] tx_byte;
  } ssp_req_s;

  // pin bundle toward the pads (value plus output enable)
  typedef struct packed {
    logic sclk;
    logic sclk_oe;
    logic port1_enable;
    logic port0_enable;
    logic en_oe;
    logic data_out;
    logic data_oe;
  } ssp_pins_s;
endpackage

// ### ssp_port.sv
// synchronous serial port master: serial clock, enables and one shared data line
//
// Summary of operation
// R1: serial clock is internal clock divided 2/4/8/16
// R2: register access starts exactly eight serial clocks
// R3: serial clock idles high between transfers
// R4: serial clock floats in emulation mode
// R5: one shared data line, sent and sampled
// R6: undriven data line kept at last value outside emulation mode
// R7: one port enable held for whole transfer
// R8: port enables low when nothing transfers
// R9: port enables float in emulation mode
// R10: one bit per serial clock, one byte
// R11: slave drives data only in receive
`timescale 1ns/100ps
module ssp_port
  import ssp_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire ssp_req_s req,
  input wire logic on_chip_emulation_mode,
  input wire logic ser_data_in,
  output logic busy,
  output logic done,
  output logic [7:0] rx_byte,
  output ssp_pins_s pins
);

  ssp_state_e state_q; // transfer engine state
  logic [2:0] half_q; // half-period countdown
  logic [2:0] half_len_q; // half-period length latched at start
  logic [2:0] bit_q; // bit index within the byte
  logic [7:0] shift_q; // transmit / receive shift register
  logic port_q; // port chosen for this transfer
  logic write_q; // direction: 1 sends, 0 receives
  logic sclk_q; // serial clock level
  logic en1_q; // port 1 enable level
  logic en0_q; // port 0 enable level
  logic keep_q; // last value seen on the data line
  logic emu_s1_q, emu_s2_q, emu_s3_q; // emulation pin synchroniser
  logic emu_q; // filtered emulation mode
  logic din_s1_q, din_s2_q, din_s3_q; // data pin synchroniser
  logic din_q; // filtered data input
  logic half_tick; // end of a half period
  logic [2:0] half_len_d; // half length for requested divider

  // divider selection to half-period length
  always_comb
  begin
    case (req.div_sel)
      SSP_DIV2: half_len_d = SSP_HALF2; // [R1]
      SSP_DIV4: half_len_d = SSP_HALF4; // [R1]
      SSP_DIV8: half_len_d = SSP_HALF8; // [R1]
      SSP_DIV16: half_len_d = SSP_HALF16; // [R1]
      default: half_len_d = SSP_HALF2;
    endcase
  end

  // one-cycle enable pulse at the end of each half serial period
  assign half_tick = (state_q != SSP_IDLE) && (half_q == 3'h0);

  // emulation mode pin: three flops, change taken when last two agree
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      emu_s1_q <= 1'b0;
      emu_s2_q <= 1'b0;
      emu_s3_q <= 1'b0;
      emu_q <= 1'b0;
    end
    else
    begin
      emu_s1_q <= on_chip_emulation_mode;
      emu_s2_q <= emu_s1_q;
      emu_s3_q <= emu_s2_q;
      if (emu_s2_q == emu_s3_q)
        emu_q <= emu_s3_q;
    end
  end

  // data pin synchroniser, same scheme; adds latency so receive samples the right bit only at divide by 16
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      din_s1_q <= 1'b0;
      din_s2_q <= 1'b0;
      din_s3_q <= 1'b0;
      din_q <= 1'b0;
    end
    else
    begin
      din_s1_q <= ser_data_in;
      din_s2_q <= din_s1_q;
      din_s3_q <= din_s2_q;
      if (din_s2_q == din_s3_q)
        din_q <= din_s3_q;
    end
  end

  // transfer sequencer: low half, high half, eight times
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      state_q <= SSP_IDLE;
      half_q <= 3'h0;
      half_len_q <= SSP_HALF2;
      bit_q <= 3'h0;
      sclk_q <= 1'b1;
    end
    else
    begin
      case (state_q)
        SSP_IDLE:
        begin
          sclk_q <= 1'b1; // [R3]
          if (req.start) // [R2]
          begin
            half_len_q <= half_len_d; // [R1]
            half_q <= half_len_d;
            bit_q <= 3'h0;
            sclk_q <= 1'b0;
            state_q <= SSP_LOW;
          end
        end
        SSP_LOW:
        begin
          if (half_tick)
          begin
            sclk_q <= 1'b1; // rising edge: slave and master sample here
            half_q <= half_len_q;
            state_q <= SSP_HIGH;
          end
          else
            half_q <= half_q - 3'h1;
        end
        SSP_HIGH:
        begin
          if (half_tick)
          begin
            half_q <= half_len_q;
            if (bit_q == SSP_LAST_BIT) // [R2] [R10]
            begin
              state_q <= SSP_IDLE; // clock stays high after the eighth cycle [R3]
            end
            else
            begin
              bit_q <= bit_q + 3'h1;
              sclk_q <= 1'b0;
              state_q <= SSP_LOW;
            end
          end
          else
            half_q <= half_q - 3'h1;
        end
        default:
        begin
          state_q <= SSP_IDLE;
          sclk_q <= 1'b1;
        end
      endcase
    end
  end

  // shift register: msb first; receive samples on the serial clock rise, send moves on the fall
  // so the outgoing bit never changes at the edge the slave samples on
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      shift_q <= 8'h00;
      write_q <= 1'b0;
      port_q <= SSP_PORT0;
    end
    else if (state_q == SSP_IDLE && req.start)
    begin
      shift_q <= req.tx_byte;
      write_q <= req.write;
      port_q <= req.port;
    end
    else if (state_q == SSP_LOW && half_tick && !write_q)
      shift_q <= {shift_q[6:0], din_q}; // sample at the rise [R5] [R10]
    else if (state_q == SSP_HIGH && half_tick && write_q && bit_q != SSP_LAST_BIT)
      shift_q <= {shift_q[6:0], 1'b0}; // next bit out at the fall [R5] [R10]
  end

  // port enables: exactly one high for the transfer, both low otherwise
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      en1_q <= 1'b0;
      en0_q <= 1'b0;
    end
    else if (state_q == SSP_IDLE && req.start)
    begin
      en1_q <= (req.port == SSP_PORT1); // [R7]
      en0_q <= (req.port == SSP_PORT0); // [R7]
    end
    else if (state_q == SSP_HIGH && half_tick && bit_q == SSP_LAST_BIT)
    begin
      en1_q <= 1'b0; // [R8]
      en0_q <= 1'b0; // [R8]
    end
  end

  // keeper: remember the last level of the line so it never floats outside emulation mode
  // only follows the pin while the slave drives it; re-sampling our own drive would
  // feed the lagging filter back into the line and replay old bits
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      keep_q <= 1'b0;
    else if (state_q != SSP_IDLE && write_q)
      keep_q <= shift_q[7]; // [R6]
    else if (state_q != SSP_IDLE && !write_q)
      keep_q <= din_q; // [R6]
  end

  // received byte and completion pulse
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      rx_byte <= 8'h00;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (state_q == SSP_HIGH && half_tick && bit_q == SSP_LAST_BIT)
      begin
        rx_byte <= shift_q;
        done <= 1'b1;
      end
    end
  end

  assign busy = (state_q != SSP_IDLE);

  // pad drive; the slave owns the line only in a receive transfer [R11]
  always_comb
  begin
    pins.sclk = sclk_q;
    pins.sclk_oe = !emu_q; // [R4]
    pins.port1_enable = en1_q;
    pins.port0_enable = en0_q;
    pins.en_oe = !emu_q; // [R9]
    pins.data_out = (busy && write_q) ? shift_q[7] : keep_q; // [R5] [R6]
    pins.data_oe = !emu_q && (busy ? write_q : 1'b1); // weak hold when idle [R6]
  end
endmodule

// ### ssp_port_assertions.sv
// checker: pin timing of the serial port
`timescale 1ns/100ps
module ssp_port_chk
  import ssp_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire ssp_req_s req,
  input wire logic on_chip_emulation_mode,
  input wire logic ser_data_in,
  input wire logic busy,
  input wire logic done,
  input wire logic [7:0] rx_byte,
  input wire ssp_pins_s pins
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic go; // start taken this edge
  logic [3:0] fall_q; // clock falls in this byte
  assign go = req.start && !busy;
  // cleared after done, so a short byte shows
  always_ff @(posedge clock)
    if (sys_rst || done) fall_q <= 4'h0;
    else if ($fell(pins.sclk)) fall_q <= fall_q + 4'h1;
  idle_high_a: assert property (!busy && pins.sclk_oe |-> pins.sclk)
    else $error("clock low at rest");
  sclk_float_a: assert property (on_chip_emulation_mode [*5] |-> !pins.sclk_oe)
    else $error("clock driven");
  en_float_a: assert property (on_chip_emulation_mode [*5] |-> !pins.en_oe)
    else $error("enables driven");
  en_low_a: assert property (!busy |-> !pins.port1_enable && !pins.port0_enable)
    else $error("enable at rest");
  one_port_a: assert property (busy |-> pins.port1_enable != pins.port0_enable)
    else $error("enable count");
  port_pick_a: assert property (go |=> busy && pins.port1_enable == $past(req.port))
    else $error("wrong port");
  fast_len_a: assert property (go && req.div_sel == SSP_DIV2 |-> ##17 done)
    else $error("bad length");
  eight_clk_a: assert property (done |-> fall_q == 4'h8)
    else $error("clock count");
  data_hold_a: assert property (busy && pins.data_oe && $rose(pins.sclk) |-> $stable(pins.data_out))
    else $error("data moved at rise");
endmodule
bind ssp_port ssp_port_chk u_chk (.clock(clock), .sys_rst(sys_rst), .req(req),
  .on_chip_emulation_mode(on_chip_emulation_mode), .ser_data_in(ser_data_in),
  .busy(busy), .done(done), .rx_byte(rx_byte), .pins(pins));

// ### ssp_port_bench.sv
// bench: transfers checked against the slave model
`timescale 1ns/100ps
module ssp_port_bench;
  import ssp_pkg::*;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic emu = 1'b0;
  logic rx_mode = 1'b0;
  logic line, busy, done;
  logic [7:0] reply = 8'h00;
  logic [7:0] heard, rx_byte;
  ssp_req_s req = '0;
  ssp_pins_s pins;
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;
  always #50 clock = ~clock;
  ssp_port u_dut (.clock(clock), .sys_rst(sys_rst), .req(req),
    .on_chip_emulation_mode(emu), .ser_data_in(line), .busy(busy),
    .done(done), .rx_byte(rx_byte), .pins(pins));
  ssp_slave_model u_slave (.pins(pins), .rx_mode(rx_mode), .reply(reply),
    .line(line), .heard(heard));
  task automatic check(logic [15:0] seen, logic [15:0] want);
    num_checks++;
    if (seen !== want)
    begin
      n_fail++;
      $display("mismatch %0t saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic close_out();
    $display("checks %0d fails %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // one byte; n is edges from start taken to done
  task automatic xfer(logic p, logic w, logic [1:0] d, logic [7:0] tx, output int n);
    n = 0;
    @(posedge clock);
    rx_mode <= !w;
    req <= '{1'b1, p, w, d, tx};
    @(posedge clock);
    req.start <= 1'b0;
    while (done !== 1'b1 && n < 300)
    begin
      @(posedge clock);
      #1;
      n++;
    end
  endtask
  // send at each divider, both ports
  task automatic t_write();
    int n;
    for (int d = 0; d < 4; d++)
    begin
      xfer(d[0], 1'b1, d[1:0], 8'hA5 ^ d[7:0], n);
      check(16'(n), 16'h10 << d);
      check(16'(heard), 16'h00A5 ^ d[15:0]);
      // idle line keeps the last bit sent, bit 0 of the byte
      check(16'({pins.data_oe, pins.data_out}), 16'({1'b1, ~d[0]}));
    end
    $display("write done");
  endtask
  // receive a byte from the slave
  task automatic t_read();
    int n;
    reply <= 8'hC3;
    xfer(1'b1, 1'b0, SSP_DIV16, 8'h00, n);
    check(16'(rx_byte), 16'h00C3);
    // keeper holds the slave's last bit once the line is ours again
    check(16'({pins.data_oe, pins.data_out}), 16'h0003);
    $display("read done");
  endtask
  // emulation floats clock and enables
  task automatic t_emu();
    @(posedge clock);
    emu <= 1'b1;
    repeat (6) @(posedge clock);
    #1;
    check({pins.sclk_oe, pins.en_oe}, 16'h0);
    $display("emu done");
  endtask
  // hang guard, run needs under 700 cycles
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      close_out();
    end
  end
  initial
  begin
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    t_write();
    t_read();
    t_emu();
    close_out();
  end
endmodule

// ### ssp_slave_model.sv
// slave model: shifts a byte on the shared line
`timescale 1ns/100ps
module ssp_slave_model
  import ssp_pkg::*;
(
  input wire ssp_pins_s pins,
  input wire logic rx_mode,
  input wire logic [7:0] reply,
  output logic line,
  output logic [7:0] heard
);
  logic [2:0] k = 3'h0; // rises seen, wraps per byte
  logic bit_q = 1'b0; // bit put out
  logic sel; // either port enabled
  assign sel = pins.port1_enable | pins.port0_enable;
  // sample on rise, msb first
  always @(posedge pins.sclk)
    if (sel)
    begin
      heard <= {heard[6:0], line};
      k <= k + 3'h1;
    end
  // next bit on the fall
  always @(negedge pins.sclk) bit_q <= reply[~k];
  // drives only in receive while enabled; undriven shows inverse
  assign line = pins.data_oe ? pins.data_out : (sel && rx_mode) ? bit_q : ~pins.data_out;
endmodule
